// >>> design/vfd_scan_ctrl.sv
// Tube scan controller with its four-wire host serial port.
//
// Contract
// - Host word is address byte then data.
// - Input bit reaches serial output 15 clocks later.
// - Shift on rising clock only while selected.
// - Select rising latches word and executes it.
// - Only last sixteen bits received are latched.
// - Read sets top bit; low byte discarded.
// - Read loads register into low shift byte.
// - Next command shifts out address then data.
// - Tube clock runs at half oscillator rate.
// - Tube stream length up to 122 bits.
// - Tube data changes on falling tube clock.
// - Latch-load high transfers, low holds pattern.
// - Blank output active level is selectable.
// - Shift next grid, load at slot start.
// - Grid count clamps to 0x2f maximum.
// - Grid write blanks one whole multiplex slot.
// - Brightness nibble sets unblanked sixteenths.
// - Every slot starts with one-sixteenth blanking.
// - Shift limit clamps to 0x79 maximum.
// - Polarity register selects blank active level.
// - No-op write changes nothing at all.
`timescale 1ns/10ps

module vfd_scan_ctrl
  import vfd_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic din,
  output logic      dout,
  output logic      tube_shift_clock,
  output logic      tube_shift_data,
  output logic      tube_latch_load,
  output logic      tube_blank_out
);

  vfd_state_t st;
  vfd_state_t next_st;

  logic        osc_tick;
  logic        host_shift;
  logic        cs_rise;
  logic [15:0] cmd;
  logic [3:0]  on_steps;
  logic [8:0]  unblank_end;
  logic        blank_now;

  // Clamps an out-of-range register write to its ceiling.
  function automatic logic [7:0] clamp(input logic [7:0] v,
                                       input logic [7:0] top);
    clamp = (v > top) ? top : v;
  endfunction

  // Grid that follows g in the scan, wrapping after the programmed count.
  function automatic logic [5:0] adv_grid(input logic [5:0] g,
                                          input logic [7:0] cnt);
    adv_grid = (g >= cnt[5:0]) ? 6'h00 : 6'(g + 6'h01);
  endfunction

  // Value presented for a read of the given register address.
  function automatic logic [7:0] read_reg(input logic [6:0] a,
                                          input vfd_state_t s);
    unique case (a)
      ADDR_BRIGHT: read_reg = s.bright;
      ADDR_GRID:   read_reg = s.grid;
      ADDR_POL:    read_reg = s.pol;
      ADDR_LIMIT:  read_reg = s.limit;
      ADDR_STATUS: read_reg = {2'b00, s.cur_grid};
      default:     read_reg = 8'h00;
    endcase
  endfunction

  // Host pins are only ever read from the second synchroniser stage.
  assign host_shift = !st.sync2[1] && st.sync2[2] && !st.sclk_prev;
  assign cs_rise    = st.sync2[1] && !st.cs_prev;
  assign osc_tick   = (st.div_cnt == DIV_LAST);
  assign cmd        = st.sr;

  // Unblanked window follows the fixed lead-in; step 15 repeats 15/16.
  assign on_steps    = (st.bright[3:0] == BRIGHT_TOP) ? 4'he
                                                    : st.bright[3:0];
  assign unblank_end = 9'(BLANK_LEAD + BLANK_LEAD * (on_steps + 4'h1));
  assign blank_now   = st.blank_slot || (st.slot_cnt < BLANK_LEAD)
                       || (st.slot_cnt >= unblank_end);

  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.sync1     = {sclk, cs_n, din};
      next_st.sync2     = st.sync1;
      next_st.sclk_prev = st.sync2[2];
      next_st.cs_prev   = st.sync2[1];

      // Multiplex oscillator.
      next_st.div_cnt = osc_tick ? 6'h00 : 6'(st.div_cnt + 6'h01);

      if (osc_tick) begin
        next_st.slot_cnt = (st.slot_cnt == SLOT_LAST)
                           ? 9'h000 : 9'(st.slot_cnt + 9'h001);
        unique case (st.scan)
          SC_HOLD: begin
            if (st.slot_cnt == SLOT_LAST) begin
              // Apply the pattern shifted during the slot just ended.
              next_st.scan       = SC_LOAD;
              next_st.tload      = 1'b1;
              next_st.cur_grid   = adv_grid(st.cur_grid, st.grid);
              next_st.blank_slot = st.pend;
              next_st.pend       = 1'b0;
              next_st.bit_idx    = 7'h00;
              next_st.tclk       = 1'b0;
              next_st.tdata      = (adv_grid(adv_grid(st.cur_grid, st.grid),
                                             st.grid) == 6'h00);
            end
          end
          SC_LOAD: begin
            next_st.tload = 1'b0;
            next_st.scan  = SC_SHIFT;
          end
          SC_SHIFT: begin
            next_st.tclk = !st.tclk;
            if (st.tclk) begin
              // Data moves only as the tube clock falls.
              if (st.bit_idx >= st.limit[6:0]) begin
                next_st.scan  = SC_HOLD;
                next_st.tdata = 1'b0;
              end else begin
                next_st.bit_idx = 7'(st.bit_idx + 7'h01);
                next_st.tdata   = ({1'b0, adv_grid(st.cur_grid, st.grid)}
                                   == 7'(st.bit_idx + 7'h01));
              end
            end
          end
        endcase
      end

      next_st.tblank = blank_now ^ st.pol[0];

      // Host port: shift while selected, ignore the clock otherwise.
      if (host_shift) begin
        next_st.sr = {st.sr[14:0], st.sync2[0]};
      end

      if (cs_rise) begin
        if (cmd[CMD_RD_BIT]) begin
          // Address byte stays in place and leads the read-back.
          next_st.sr[7:0] = read_reg(cmd[CMD_ADDR_HI:CMD_ADDR_LO],
                                     st);
        end else begin
          unique case (cmd[CMD_ADDR_HI:CMD_ADDR_LO])
            ADDR_BRIGHT: next_st.bright = cmd[7:0];
            ADDR_GRID: begin
              next_st.grid = clamp(cmd[7:0], GRID_MAX);
              next_st.pend = 1'b1;
            end
            ADDR_POL:   next_st.pol   = cmd[7:0];
            ADDR_LIMIT: next_st.limit = clamp(cmd[7:0], LIMIT_MAX);
            default: begin
              // No-op and unmapped addresses leave every state alone.
            end
          endcase
        end
      end

      // The output bit launches with the clock edge that shifts it.
      next_st.dout = next_st.sr[15];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st            <= '0;
      st.sync1      <= 3'b010;
      st.sync2      <= 3'b010;
      st.cs_prev    <= 1'b1;
      st.grid       <= GRID_RST;
      st.bright     <= BRIGHT_RST;
      st.limit      <= LIMIT_RST;
      st.pol        <= POL_RST;
      st.blank_slot <= 1'b1;
      st.scan       <= SC_HOLD;
      st.tblank     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign dout             = st.dout;
  assign tube_shift_clock = st.tclk;
  assign tube_shift_data  = st.tdata;
  assign tube_latch_load  = st.tload;
  assign tube_blank_out   = st.tblank;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_write_grid;
    ce && cs_rise && !cmd[CMD_RD_BIT]
      && cmd[CMD_ADDR_HI:CMD_ADDR_LO] == ADDR_GRID;
  endsequence

  sequence s_write_limit;
    ce && cs_rise && !cmd[CMD_RD_BIT]
      && cmd[CMD_ADDR_HI:CMD_ADDR_LO] == ADDR_LIMIT;
  endsequence

  sequence s_read_cmd;
    ce && cs_rise && cmd[CMD_RD_BIT];
  endsequence

  sequence s_write_bright;
    ce && cs_rise && !cmd[CMD_RD_BIT]
      && cmd[CMD_ADDR_HI:CMD_ADDR_LO] == ADDR_BRIGHT;
  endsequence

  sequence s_write_pol;
    ce && cs_rise && !cmd[CMD_RD_BIT]
      && cmd[CMD_ADDR_HI:CMD_ADDR_LO] == ADDR_POL;
  endsequence

  // Last tick of a slot: the scan hands over to the next grid here.
  sequence s_slot_end;
    ce && osc_tick && st.scan == SC_HOLD && st.slot_cnt == SLOT_LAST;
  endsequence

  a_grid_clamp_hi: assert property (
    s_write_grid ##0 (cmd[7:0] > GRID_MAX) |=> st.grid == GRID_MAX)
    else $error("grid count not clamped");

  a_grid_clamp_in: assert property (
    s_write_grid ##0 (cmd[7:0] <= GRID_MAX) |=> st.grid == $past(cmd[7:0]))
    else $error("grid count not stored");

  a_limit_clamp_hi: assert property (
    s_write_limit ##0 (cmd[7:0] > LIMIT_MAX) |=> st.limit == LIMIT_MAX)
    else $error("shift limit not clamped");

  a_read_loads: assert property (
    s_read_cmd |=> st.sr == {$past(cmd[15:8]),
                             read_reg($past(cmd[14:8]), $past(st))})
    else $error("read data not loaded into low byte");

  a_idle_holds: assert property (
    ce && st.sync2[1] && st.cs_prev |=> $stable(st.sr))
    else $error("shift register moved while deselected");

  a_shift_in: assert property (
    ce && host_shift |=> st.sr == {$past(st.sr[14:0]), $past(st.sync2[0])}
                         && dout == $past(st.sr[14]))
    else $error("serial bit not shifted in");

  a_dout_edge: assert property (
    ce && !host_shift && !cs_rise |=> $stable(dout))
    else $error("serial output moved without a clock edge");

  a_tclk_tick: assert property (
    $changed(tube_shift_clock) |-> $past(osc_tick) && $past(ce))
    else $error("tube clock moved between oscillator ticks");

  a_data_on_fall: assert property (
    $changed(tube_shift_data) && $past(st.scan) == SC_SHIFT
      |-> $fell(tube_shift_clock))
    else $error("tube data moved off the falling edge");

  a_load_blanked: assert property (
    $rose(tube_latch_load) ##1 ce [*2] |-> tube_blank_out == !st.pol[0])
    else $error("slot start not blanked");

  a_grid_pend: assert property (
    s_write_grid |=> st.pend)
    else $error("grid write did not arm the blank slot");

  a_grid_blanks: assert property (
    s_slot_end ##0 st.pend |=> st.blank_slot)
    else $error("grid write did not blank the next slot");

  a_noop_quiet: assert property (
    ce && cs_rise && cmd[15:8] == 8'h00
      |=> $stable(st.grid) && $stable(st.bright) && $stable(st.limit)
          && $stable(st.pol))
    else $error("no-op write changed a register");

  a_limit_clamp_in: assert property (
    s_write_limit ##0 (cmd[7:0] <= LIMIT_MAX)
      |=> st.limit == $past(cmd[7:0]))
    else $error("shift limit not stored");

  a_bright_store: assert property (
    s_write_bright |=> st.bright == $past(cmd[7:0]))
    else $error("brightness not stored");

  a_pol_store: assert property (
    s_write_pol |=> st.pol == $past(cmd[7:0]))
    else $error("blank polarity not stored");

  a_read_quiet: assert property (
    s_read_cmd
      |=> $stable(st.grid) && $stable(st.bright) && $stable(st.limit)
          && $stable(st.pol))
    else $error("read command changed a register");

  // A load pulse that ran on would pass half-shifted data to the tubes.
  a_load_start: assert property (
    s_slot_end |=> tube_latch_load && st.scan == SC_LOAD)
    else $error("slot start did not pulse the latch load");

  a_load_one_tick: assert property (
    ce && osc_tick && st.scan == SC_LOAD
      |=> !tube_latch_load && st.scan == SC_SHIFT)
    else $error("latch load held past one tick");

  a_scan_step: assert property (
    s_slot_end ##0 (st.cur_grid < st.grid[5:0])
      |=> st.cur_grid == $past(st.cur_grid) + 6'h01)
    else $error("scan did not step to the next grid");

  a_scan_wrap: assert property (
    s_slot_end ##0 (st.cur_grid >= st.grid[5:0])
      |=> st.cur_grid == 6'h00)
    else $error("scan did not wrap to the first grid");

  a_stream_end: assert property (
    ce && osc_tick && st.scan == SC_SHIFT && st.tclk
      && st.bit_idx >= st.limit[6:0]
      |=> st.scan == SC_HOLD && !tube_shift_clock)
    else $error("stream ran past the shift limit");

  a_tclk_idle: assert property (
    st.scan != SC_SHIFT |-> !tube_shift_clock)
    else $error("tube clock high outside the shift phase");

  // The lead-in must not depend on the brightness setting.
  a_lead_blank: assert property (
    ce && st.slot_cnt < BLANK_LEAD
      |=> tube_blank_out == !$past(st.pol[0]))
    else $error("slot lead-in not blanked");

  a_slot_blank: assert property (
    ce && st.blank_slot |=> tube_blank_out == !$past(st.pol[0]))
    else $error("blanked slot let the tubes light");

endmodule

// >>> design/vfd_pkg.sv
// Constants, register map and state types of the tube scan controller.
package vfd_pkg;

  // Clock rates and the multiplex oscillator derived from the core clock.
  localparam int CLK_HZ         = 200_000_000;
  localparam int OSC_HZ         = 4_000_000;
  localparam int OSC_DIV        = CLK_HZ / OSC_HZ;
  localparam logic [5:0] DIV_LAST = 6'(OSC_DIV - 1);

  // One grid period and its minimum blanked lead-in, in oscillator ticks.
  localparam int MUX_PERIOD_US  = 100;
  localparam int SLOT_TICKS     = MUX_PERIOD_US * (OSC_HZ / 1_000_000);
  localparam int MIN_BLANK_NS   = 6250;
  localparam int MIN_BLANK_TICKS =
    (MIN_BLANK_NS * (OSC_HZ / 1_000_000) + 999) / 1000;
  localparam logic [8:0] SLOT_LAST = 9'(SLOT_TICKS - 1);
  localparam logic [8:0] BLANK_LEAD = 9'(MIN_BLANK_TICKS);

  // Command word layout.
  localparam int CMD_RD_BIT     = 15;
  localparam int CMD_ADDR_HI    = 14;
  localparam int CMD_ADDR_LO    = 8;

  // Register addresses.
  localparam logic [6:0] ADDR_NOOP   = 7'h00;
  localparam logic [6:0] ADDR_BRIGHT = 7'h02;
  localparam logic [6:0] ADDR_GRID   = 7'h03;
  localparam logic [6:0] ADDR_POL    = 7'h0c;
  localparam logic [6:0] ADDR_LIMIT  = 7'h0e;
  localparam logic [6:0] ADDR_STATUS = 7'h0f;

  // Clamp ceilings and values after reset.
  localparam logic [7:0] GRID_MAX    = 8'h2f;
  localparam logic [7:0] LIMIT_MAX   = 8'h79;
  localparam logic [7:0] GRID_RST    = 8'h07;
  localparam logic [7:0] BRIGHT_RST  = 8'h07;
  localparam logic [7:0] LIMIT_RST   = 8'h79;
  localparam logic [7:0] POL_RST     = 8'h00;
  localparam logic [3:0] BRIGHT_TOP  = 4'hf;

  typedef enum logic [1:0] {
    SC_LOAD  = 2'b00,
    SC_SHIFT = 2'b01,
    SC_HOLD  = 2'b11
  } vfd_scan_t;

  typedef struct packed {
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic        sclk_prev;
    logic        cs_prev;
    logic [15:0] sr;
    logic        dout;
    logic [7:0]  grid;
    logic [7:0]  bright;
    logic [7:0]  limit;
    logic [7:0]  pol;
    logic        pend;
    logic        blank_slot;
    logic [5:0]  div_cnt;
    logic [8:0]  slot_cnt;
    logic [5:0]  cur_grid;
    logic [6:0]  bit_idx;
    vfd_scan_t   scan;
    logic        tclk;
    logic        tdata;
    logic        tload;
    logic        tblank;
  } vfd_state_t;

endpackage

// >>> testbench/vfd_tube_model.sv
// Behavioural tube driver: shift register, output latch and timing probes.
`timescale 1ns/10ps

module vfd_tube_model (
  input  wire logic         clk,
  input  wire logic         tube_shift_clock,
  input  wire logic         tube_shift_data,
  input  wire logic         tube_latch_load,
  output logic      [121:0] lat,
  output int                n_bits,
  output int                hi_len,
  output int                bad
);
  logic [121:0] pat = '0;
  logic [121:0] lat_q = '0;
  logic         pclk = 1'b0;
  logic         pload = 1'b0;
  logic         d_s = 1'b0;
  int           k = 0;
  int           hi = 0;
  int           n_q = 0;
  int           hl_q = 0;
  int           bad_q = 0;

  // Each output has a single driver and starts from zero.
  assign lat    = lat_q;
  assign n_bits = n_q;
  assign hi_len = hl_q;
  assign bad    = bad_q;

  // Edges are found from the core clock so no event races the data change.
  always @(posedge clk) begin
    if (tube_shift_clock && !pclk) begin
      pat[k] <= tube_shift_data;
      d_s <= tube_shift_data;
      k <= k + 1;
      hi <= 1;
    end
    if (tube_shift_clock && pclk) begin
      hi <= hi + 1;
      if (tube_shift_data !== d_s) begin
        bad_q <= bad_q + 1;
      end
    end
    if (!tube_shift_clock && pclk) begin
      hl_q <= hi;
    end
    if (tube_latch_load && !pload) begin
      n_q <= k;
      k <= 0;
    end
    if (tube_latch_load) begin
      lat_q <= pat;
    end
    pclk <= tube_shift_clock;
    pload <= tube_latch_load;
  end
endmodule

// >>> testbench/test_vfd_scan_controller_serial_port.sv
// Bench: host serial frames, register checks and tube timing checks.
`timescale 1ns/10ps

module test_vfd_scan_controller_serial_port
  import vfd_pkg::*;
;
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  logic         sclk = 1'b0;
  logic         cs_n = 1'b1;
  logic         din = 1'b0;
  logic         ce = 1'b1;
  logic         dout;
  logic         tube_shift_clock;
  logic         tube_shift_data;
  logic         tube_latch_load;
  logic         tube_blank_out;
  logic [121:0] lat;
  logic [15:0]  rx;
  int           n_bits;
  int           hi_len;
  int           bad;
  int           n_errors = 0;
  int           cmp_count = 0;
  int           n;
  int           g2;
  int           slot;

  initial begin
    forever #2.5 clk = ~clk;
  end

  vfd_scan_ctrl u_vfd_scan_ctrl (
    .clk(clk), .nrst(nrst), .ce(ce), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .tube_shift_clock(tube_shift_clock),
    .tube_shift_data(tube_shift_data), .tube_latch_load(tube_latch_load),
    .tube_blank_out(tube_blank_out)
  );

  vfd_tube_model u_vfd_tube_model (
    .clk(clk), .tube_shift_clock(tube_shift_clock),
    .tube_shift_data(tube_shift_data), .tube_latch_load(tube_latch_load),
    .lat(lat), .n_bits(n_bits), .hi_len(hi_len), .bad(bad)
  );

  task end_sim;
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen,
             input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tick(input int c);
    repeat (c) @(negedge clk);
  endtask

  // One host bit: the read-back bit is taken before the rising edge.
  task bit_tx(input logic b, output logic d);
    sclk = 1'b0;
    din = b;
    tick(16);
    d = dout;
    sclk = 1'b1;
    tick(16);
  endtask

  task frame_end;
    cs_n = 1'b1;
    tick(8);
    sclk = 1'b0;
    tick(8);
  endtask

  // Extra leading ones model an over-long frame.
  task xfer(input logic [15:0] wd, input int extra, output logic [15:0] r);
    logic j;
    cs_n = 1'b0;
    tick(4);
    repeat (extra) bit_tx(1'b1, j);
    for (int i = 15; i >= 0; i--) bit_tx(wd[i], r[i]);
    frame_end();
  endtask

  task xfer8(input logic [7:0] wd);
    logic j;
    cs_n = 1'b0;
    tick(4);
    for (int i = 7; i >= 0; i--) bit_tx(wd[i], j);
    frame_end();
  endtask

  task wr(input logic [6:0] a, input logic [7:0] d);
    xfer({1'b0, a, d}, 0, rx);
  endtask

  // The top bit of the echoed address is the read flag and is not compared.
  task rd(input logic [6:0] a, input logic [7:0] exp);
    xfer({1'b1, a, 8'hff}, 0, rx);
    xfer(16'h0000, 0, rx);
    check("readback", {17'h0, rx[14:0]}, {17'h0, a, exp});
  endtask

  task wait_on(input logic sel_blank, input logic lvl, output int c);
    for (c = 1; c < 25000; c++) begin
      @(negedge clk);
      if ((sel_blank ? tube_blank_out : tube_latch_load) === lvl) return;
    end
    n_errors++;
    $display("ERROR tube_wait expected edge seen none");
    end_sim();
  endtask

  function automatic int idx(logic [7:0] v);
    for (int i = 0; i < 8; i++) if (v === 8'h01 << i) return i;
    return 99;
  endfunction

  initial begin
    slot = SLOT_TICKS * OSC_DIV;
    tick(6);
    nrst = 1'b1;
    tick(1);
    check("blank_rst", tube_blank_out, 1);
    check("load_rst", {tube_latch_load, dout}, 0);
    check("dout_rst", dout, 0);
    rd(ADDR_GRID, GRID_RST);
    rd(ADDR_BRIGHT, BRIGHT_RST);
    rd(ADDR_LIMIT, LIMIT_RST);
    rd(ADDR_POL, POL_RST);
    wr(ADDR_GRID, 8'h30);
    rd(ADDR_GRID, GRID_MAX);
    wr(ADDR_LIMIT, 8'h7a);
    rd(ADDR_LIMIT, LIMIT_MAX);
    wr(ADDR_LIMIT, 8'h07);
    xfer(16'h00ff, 0, rx);
    check("chain", {17'h0, rx[14:0]}, {17'h0, ADDR_LIMIT, 8'h07});
    rd(ADDR_LIMIT, 8'h07);
    din = 1'b1;
    repeat (8) begin
      sclk = 1'b1;
      tick(16);
      sclk = 1'b0;
      tick(16);
    end
    xfer8(8'h02);
    xfer8(8'h09);
    rd(ADDR_BRIGHT, 8'h09);
    xfer({1'b0, ADDR_BRIGHT, 8'h03}, 4, rx);
    rd(ADDR_BRIGHT, 8'h03);
    // A frame sent while the clock enable is low must be lost entirely.
    ce = 1'b0;
    wr(ADDR_BRIGHT, 8'h05);
    tick(4);
    ce = 1'b1;
    rd(ADDR_BRIGHT, 8'h03);
    wr(ADDR_GRID, 8'h02);
    wait_on(1'b0, 1'b1, n);
    wait_on(1'b1, 1'b0, n);
    n = n - slot - MIN_BLANK_TICKS * OSC_DIV;
    check("lead", n >= -1 && n <= 1, 1);
    wait_on(1'b1, 1'b1, n);
    check("unblank", n, 4 * (SLOT_TICKS / 16) * OSC_DIV);
    check("bits", n_bits, 8);
    check("clk_high", hi_len, OSC_DIV);
    g2 = idx(lat[7:0]);
    check("grid_range", g2 < 3, 1);
    wr(ADDR_POL, 8'h01);
    wait_on(1'b0, 1'b1, n);
    tick(100);
    check("blank_pol", tube_blank_out, 0);
    check("grid_next", idx(lat[7:0]), (g2 + 1) % 3);
    check("data_stable", bad, 0);
    end_sim();
  end
endmodule
